/* File: logic/pic_pkg.sv */
// constants, field layouts and vector table of the priority interrupt controller
package pic_pkg;

	// ----------------------------------------------------------------
	// register map: printed indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam int          MIN_ADDR_W      = 18;
	localparam logic [15:0] LEVEL_CFG_INDEX = 16'hffff;
	localparam logic [15:0] CTRL_INDEX      = 16'hffc0;
	localparam logic [15:0] STATUS_INDEX    = 16'hffc1;
	localparam logic [17:0] LEVEL_CFG_ADDR  = {LEVEL_CFG_INDEX, 2'b00};
	localparam logic [17:0] CTRL_ADDR       = {CTRL_INDEX, 2'b00};
	localparam logic [17:0] STATUS_ADDR     = {STATUS_INDEX, 2'b00};

	// ----------------------------------------------------------------
	// interrupt_level_config fields
	// ----------------------------------------------------------------
	localparam int          EXT_A_LSB       = 0;
	localparam int          EXT_B_LSB       = 3;
	localparam int          EXT_EDGE_OFS    = 2;
	localparam int          AUDIO_LSB       = 10;
	localparam int          HOST_LSB        = 12;
	localparam int          MEMORY_LSB      = 14;
	localparam logic [23:0] LEVEL_CFG_RW    = 24'h00_fc3f;
	localparam logic [23:0] LEVEL_CFG_RESET = 24'h00_0000;

	// ----------------------------------------------------------------
	// control and status fields
	// ----------------------------------------------------------------
	localparam int          TX_BANK_BIT     = 0;
	localparam int          RX_BANK_BIT     = 1;
	localparam int          MASK_LSB        = 8;
	localparam logic [1:0]  MASK_RESET      = 2'h3;
	localparam int          STAT_VEC_LSB    = 0;
	localparam int          STAT_LEVEL_LSB  = 16;
	localparam int          STAT_VALID_BIT  = 24;
	localparam int          STAT_NM_LSB     = 25;

	// ----------------------------------------------------------------
	// sources and vectors
	// ----------------------------------------------------------------
	localparam int          NUM_NM          = 5;
	localparam int          NUM_MASKABLE    = 18;
	localparam logic [4:0]  SRC_RESET       = 5'h00;
	localparam logic [4:0]  SRC_EXT_A       = 5'h06;
	localparam logic [4:0]  SRC_EXT_B       = 5'h07;
	localparam logic [1:0]  NM_LEVEL        = 2'h3;
	localparam logic [15:0] VEC_RESET       = 16'h0000;
	localparam logic [15:0] VEC_EXT_B       = 16'h000a;
	localparam logic [15:0] VEC_SWI         = 16'h0006;
	localparam logic [15:0] BANK_OFFSET     = 16'h0030;
	localparam logic [15:0] VEC_BANK_HIGH   = 16'h0040;
	// illegal instruction, nmi, stack error, trace, software trap
	localparam logic [15:0] NM_VEC [NUM_NM] = '{16'h003e, 16'h001e, 16'h0002, 16'h0004,
		16'h0006};
	// maskable sources in fixed tie order, low index wins
	localparam logic [15:0] MASKABLE_VEC [NUM_MASKABLE] = '{
		16'h0008, 16'h000a, 16'h001a, 16'h0014, 16'h0016, 16'h0010, 16'h0018, 16'h0012,
		16'h002c, 16'h002a, 16'h0022, 16'h0028, 16'h0020, 16'h0024,
		16'h0034, 16'h0036, 16'h0032, 16'h0030};
	localparam logic [17:0] TX_SRC_MASK     = 18'h0_00a8;
	localparam logic [17:0] RX_SRC_MASK     = 18'h0_0054;

	// ----------------------------------------------------------------
	// bus
	// ----------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum logic {WR_ACCEPT = 1'b0, WR_RESP = 1'b1} wr_state_t;
	typedef enum logic {RD_ACCEPT = 1'b0, RD_RESP = 1'b1} rd_state_t;

endpackage

/* File: logic/priority_interrupt_controller.sv */
// priority interrupt controller with vector selection and axi4-lite registers
// Summary of operation
// - 24-bit software-written level configuration register
// - sources programmable to levels 0-2 by writes
// - bits 0-5 hold request A/B fields
// - request A beats B at equal level
// - bits 6-9 and 16-23 reserved, no function
// - bits 10-15 hold three 2-bit group fields
// - nonmaskable order: reset, illegal, nmi, stack, trace, trap
// - maskable ties: A, B, audio sources first
// - then host sources, then memory sources
// - fixed core vectors for core sources
// - transmit bank bit moves audio transmit vectors
// - receive bank bit moves audio receive vectors
// - fixed host serial vectors
// - fixed external memory vectors
// - reset clears the level configuration register
// - reset sets both control word mask bits
// - held in reset, then fetch from 0000
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module priority_interrupt_controller #(
	parameter int ADDR_W = 18
) (
	// clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              reset_n_in,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp_out,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	// external request pins, active low
	input  wire logic              ext_request_a_n_in,
	input  wire logic              ext_request_b_n_in,
	// nonmaskable event pulses
	input  wire logic              illegal_instr_in,
	input  wire logic              nmi_in,
	input  wire logic              stack_error_in,
	input  wire logic              trace_in,
	input  wire logic              software_trap_in,
	// peripheral group request levels
	input  wire logic [5:0]        audio_req_in,
	input  wire logic [5:0]        host_req_in,
	input  wire logic [3:0]        memory_req_in,
	// vector handshake with the core sequencer
	output logic                   vector_valid_out,
	output logic [15:0]            vector_out,
	output logic [1:0]             vector_level_out,
	input  wire logic              vector_ack_in
);

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (ADDR_W < pic_pkg::MIN_ADDR_W) begin : g_bad_addr_w
		$error("ADDR_W too narrow for the register map");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [23:0]       level_cfg;
		logic              tx_bank;
		logic              rx_bank;
		logic [1:0]        mask;
		logic              reset_pend;
		logic [4:0]        nm_pend;
		logic              ext_a_edge;
		logic              ext_b_edge;
		logic              ext_a_prev;
		logic              ext_b_prev;
		logic              vec_valid;
		logic [15:0]       vec;
		logic [1:0]        vec_level;
		logic [4:0]        vec_src;
		pic_pkg::wr_state_t wr_state;
		logic              awready;
		logic              wready;
		logic              aw_held;
		logic              w_held;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		pic_pkg::rd_state_t rd_state;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              first_cycle;
		logic              seen_vec;
	} state_t;

	state_t s;
	state_t next_s;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// a level code of zero disables, codes 1..3 mean levels 0..2
	function automatic logic accepted(input logic [1:0] code, input logic [1:0] mask);
		accepted = (code != 2'h0) && ((code - 2'h1) >= mask);
	endfunction

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[b*8 +: 8] = data[b*8 +: 8];
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// source requests and level codes
	// ----------------------------------------------------------------
	logic [17:0] src_req;
	logic [1:0]  src_code [pic_pkg::NUM_MASKABLE];
	logic        ext_a_active;
	logic        ext_b_active;
	logic        a_b_tie;

	// edge-mode request latches, else pin level
	assign ext_a_active = s.level_cfg[pic_pkg::EXT_A_LSB + pic_pkg::EXT_EDGE_OFS] ?
		s.ext_a_edge : !ext_request_a_n_in;
	assign ext_b_active = s.level_cfg[pic_pkg::EXT_B_LSB + pic_pkg::EXT_EDGE_OFS] ?
		s.ext_b_edge : !ext_request_b_n_in;
	assign src_req = {memory_req_in, host_req_in, audio_req_in, ext_b_active, ext_a_active};
	assign a_b_tie = src_req[0] && src_req[1] && (src_code[0] == src_code[1]) &&
		accepted(src_code[0], s.mask);

	// each group shares its field; audio 10-11, host 12-13, memory 14-15
	always_comb begin
		src_code[0] = s.level_cfg[pic_pkg::EXT_A_LSB +: 2];
		src_code[1] = s.level_cfg[pic_pkg::EXT_B_LSB +: 2];
		for (int i = 2; i < pic_pkg::NUM_MASKABLE; i++) begin
			if (i < 8) begin
				src_code[i] = s.level_cfg[pic_pkg::AUDIO_LSB +: 2];
			end else if (i < 14) begin
				src_code[i] = s.level_cfg[pic_pkg::HOST_LSB +: 2];
			end else begin
				src_code[i] = s.level_cfg[pic_pkg::MEMORY_LSB +: 2];
			end
		end
	end

	// ----------------------------------------------------------------
	// arbiter: nonmaskable first, then highest level, then fixed order
	// ----------------------------------------------------------------
	logic        arb_valid;
	logic [15:0] arb_vec;
	logic [1:0]  arb_level;
	logic [4:0]  arb_src;

	always_comb begin
		arb_valid = 1'b0;
		arb_vec   = pic_pkg::VEC_RESET;
		arb_level = pic_pkg::NM_LEVEL;
		arb_src   = pic_pkg::SRC_RESET;
		if (s.reset_pend) begin
			arb_valid = 1'b1;
		end else begin
			for (int i = pic_pkg::NUM_NM - 1; i >= 0; i--) begin
				if (s.nm_pend[i]) begin
					arb_valid = 1'b1;
					arb_vec   = pic_pkg::NM_VEC[i];
					arb_src   = 5'(i + 1);
				end
			end
			if (!arb_valid) begin
				for (int i = 0; i < pic_pkg::NUM_MASKABLE; i++) begin
					// strict compare keeps the lower index on a tie
					if (src_req[i] && accepted(src_code[i], s.mask) &&
						(!arb_valid || (src_code[i] - 2'h1) > arb_level)) begin
						arb_valid = 1'b1;
						arb_level = src_code[i] - 2'h1;
						arb_src   = 5'(i + 6);
						arb_vec   = pic_pkg::MASKABLE_VEC[i];
						if ((pic_pkg::TX_SRC_MASK[i] && s.tx_bank) ||
							(pic_pkg::RX_SRC_MASK[i] && s.rx_bank)) begin
							arb_vec = pic_pkg::MASKABLE_VEC[i] + pic_pkg::BANK_OFFSET;
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// next state: vector handshake, pending flags and bus slave
	// ----------------------------------------------------------------
	logic [4:0]  nm_in;
	logic        acked;
	logic [5:0]  clr;
	logic [31:0] cfg_merged;
	logic [31:0] ctrl_merged;

	assign nm_in = {software_trap_in, trace_in, stack_error_in, nmi_in, illegal_instr_in};
	assign acked = s.vec_valid && vector_ack_in;

	// held write data merged by byte lanes into the stored configuration word; control data is merged into zero
	assign cfg_merged  = merge({8'h00, s.level_cfg}, s.wdata, s.wstrb);
	assign ctrl_merged = merge(32'h0000_0000, s.wdata, s.wstrb);

	always_comb begin
		next_s             = s;
		next_s.first_cycle = 1'b0;
		clr                = 6'h00;
		// pending clear on acknowledge; a new event in the same cycle wins
		if (acked && s.vec_src < 5'd6) begin
			clr[s.vec_src[2:0]] = 1'b1;
		end
		next_s.reset_pend = s.reset_pend && !clr[0];
		next_s.nm_pend    = (s.nm_pend & ~clr[5:1]) | nm_in;
		next_s.ext_a_prev = ext_request_a_n_in;
		next_s.ext_b_prev = ext_request_b_n_in;
		next_s.ext_a_edge = (s.ext_a_edge && !(acked && s.vec_src == pic_pkg::SRC_EXT_A)) ||
			(s.ext_a_prev && !ext_request_a_n_in);
		next_s.ext_b_edge = (s.ext_b_edge && !(acked && s.vec_src == pic_pkg::SRC_EXT_B)) ||
			(s.ext_b_prev && !ext_request_b_n_in);
		// vector offer, dropped for one cycle after each acknowledge
		if (acked) begin
			next_s.vec_valid = 1'b0;
			next_s.seen_vec  = 1'b1;
		end else begin
			next_s.vec_valid = arb_valid;
			next_s.vec       = arb_vec;
			next_s.vec_level = arb_level;
			next_s.vec_src   = arb_src;
		end
		// write channel: address and data in either order
		unique case (s.wr_state)
			pic_pkg::WR_ACCEPT: begin
				if (s_axi_awvalid_in && s.awready) begin
					next_s.awaddr  = s_axi_awaddr_in;
					next_s.aw_held = 1'b1;
					next_s.awready = 1'b0;
				end
				if (s_axi_wvalid_in && s.wready) begin
					next_s.wdata  = s_axi_wdata_in;
					next_s.wstrb  = s_axi_wstrb_in;
					next_s.w_held = 1'b1;
					next_s.wready = 1'b0;
				end
				if (s.aw_held && s.w_held) begin
					next_s.aw_held  = 1'b0;
					next_s.w_held   = 1'b0;
					next_s.bvalid   = 1'b1;
					next_s.bresp    = pic_pkg::RESP_OKAY;
					next_s.wr_state = pic_pkg::WR_RESP;
					if (s.awaddr == ADDR_W'(pic_pkg::LEVEL_CFG_ADDR)) begin
						next_s.level_cfg = cfg_merged[23:0] & pic_pkg::LEVEL_CFG_RW;
					end else if (s.awaddr == ADDR_W'(pic_pkg::CTRL_ADDR)) begin
						next_s.tx_bank = ctrl_merged[pic_pkg::TX_BANK_BIT];
						next_s.rx_bank = ctrl_merged[pic_pkg::RX_BANK_BIT];
						if (s.wstrb[1]) begin
							next_s.mask = s.wdata[pic_pkg::MASK_LSB +: 2];
						end
					end else if (s.awaddr != ADDR_W'(pic_pkg::STATUS_ADDR)) begin
						next_s.bresp = pic_pkg::RESP_SLVERR;
					end
				end
			end
			pic_pkg::WR_RESP: begin
				if (s_axi_bready_in) begin
					next_s.bvalid   = 1'b0;
					next_s.awready  = 1'b1;
					next_s.wready   = 1'b1;
					next_s.wr_state = pic_pkg::WR_ACCEPT;
				end
			end
		endcase
		// read channel: data one cycle after the address is taken
		unique case (s.rd_state)
			pic_pkg::RD_ACCEPT: begin
				if (s_axi_arvalid_in && s.arready) begin
					next_s.arready  = 1'b0;
					next_s.rvalid   = 1'b1;
					next_s.rd_state = pic_pkg::RD_RESP;
					next_s.rresp    = pic_pkg::RESP_OKAY;
					next_s.rdata    = 32'h0000_0000;
					if (s_axi_araddr_in == ADDR_W'(pic_pkg::LEVEL_CFG_ADDR)) begin
						next_s.rdata[23:0] = s.level_cfg;
					end else if (s_axi_araddr_in == ADDR_W'(pic_pkg::CTRL_ADDR)) begin
						next_s.rdata[pic_pkg::TX_BANK_BIT]      = s.tx_bank;
						next_s.rdata[pic_pkg::RX_BANK_BIT]      = s.rx_bank;
						next_s.rdata[pic_pkg::MASK_LSB +: 2]    = s.mask;
					end else if (s_axi_araddr_in == ADDR_W'(pic_pkg::STATUS_ADDR)) begin
						next_s.rdata[pic_pkg::STAT_VEC_LSB +: 16]  = s.vec;
						next_s.rdata[pic_pkg::STAT_LEVEL_LSB +: 2] = s.vec_level;
						next_s.rdata[pic_pkg::STAT_VALID_BIT]      = s.vec_valid;
						next_s.rdata[pic_pkg::STAT_NM_LSB +: 5]    = s.nm_pend;
					end else begin
						next_s.rresp = pic_pkg::RESP_SLVERR;
					end
				end
			end
			pic_pkg::RD_RESP: begin
				if (s_axi_rready_in) begin
					next_s.rvalid   = 1'b0;
					next_s.arready  = 1'b1;
					next_s.rd_state = pic_pkg::RD_ACCEPT;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register; reset clears the configuration and masks all levels
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s             <= '0;
			s.level_cfg   <= pic_pkg::LEVEL_CFG_RESET;
			s.mask        <= pic_pkg::MASK_RESET;
			s.reset_pend  <= 1'b1;
			s.ext_a_prev  <= 1'b1;
			s.ext_b_prev  <= 1'b1;
			s.awready     <= 1'b1;
			s.wready      <= 1'b1;
			s.arready     <= 1'b1;
			s.first_cycle <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_out = s.awready;
	assign s_axi_wready_out  = s.wready;
	assign s_axi_bresp_out   = s.bresp;
	assign s_axi_bvalid_out  = s.bvalid;
	assign s_axi_arready_out = s.arready;
	assign s_axi_rdata_out   = s.rdata;
	assign s_axi_rresp_out   = s.rresp;
	assign s_axi_rvalid_out  = s.rvalid;
	assign vector_valid_out  = s.vec_valid;
	assign vector_out        = s.vec;
	assign vector_level_out  = s.vec_level;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	AST_CFG_CLEARED_AT_RESET: assert property (s.first_cycle |-> s.level_cfg == 24'h00_0000)
		else $error("level configuration not clear after reset");
	AST_MASK_SET_AT_RESET: assert property (s.first_cycle |-> s.mask == 2'h3)
		else $error("mask bits not set after reset");
	AST_FIRST_VECTOR_ZERO: assert property (s.vec_valid && !s.seen_vec |->
		s.vec == 16'h0000 && s.vec_level == 2'h3)
		else $error("first vector after reset is not the reset vector");
	AST_RESERVED_BITS_ZERO: assert property (s.level_cfg[9:6] == 4'h0 &&
		s.level_cfg[23:16] == 8'h00)
		else $error("reserved configuration bits hold a value");
	AST_WRITE_STORES_CONFIG: assert property ($rose(s.bvalid) &&
		s.awaddr == ADDR_W'(pic_pkg::LEVEL_CFG_ADDR) && s.wstrb == 4'hf |->
		s.level_cfg == (s.wdata[23:0] & 24'h00_fc3f))
		else $error("full write to level configuration not stored");
	AST_MASK_RESPECTED: assert property (s.vec_valid && s.vec_level != 2'h3 |->
		s.vec_level >= $past(s.mask))
		else $error("maskable vector offered below the mask level");
	AST_A_BEFORE_B: assert property (s.vec_valid && s.vec == 16'h000a |->
		!$past(a_b_tie))
		else $error("request B served ahead of request A at equal level");
	AST_TX_BANK_HIGH: assert property (s.vec_valid && s.vec inside {16'h0040, 16'h0042,
		16'h0044} |-> $past(s.tx_bank))
		else $error("transmit vector moved without bank select");
	AST_RX_BANK_HIGH: assert property (s.vec_valid && s.vec inside {16'h0046, 16'h0048,
		16'h004a} |-> $past(s.rx_bank))
		else $error("receive vector moved without bank select");
	AST_TRAP_LOWEST_NM: assert property (s.vec_valid && s.vec == 16'h0006 &&
		s.vec_level == 2'h3 |-> $past(s.nm_pend[3:0]) == 4'h0 && !$past(s.reset_pend))
		else $error("software trap served over a higher nonmaskable event");
	AST_ACK_DROPS_VALID: assert property (s.vec_valid && vector_ack_in |=> !s.vec_valid)
		else $error("vector still offered after acknowledge");

endmodule // priority_interrupt_controller

/* File: verification/core_sequencer_model.sv */
// core sequencer and peripheral request model facing the interrupt controller
`timescale 1ns/1ps
module core_sequencer_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	// vector offer and acknowledge
	input  wire logic        valid_in,
	input  wire logic [15:0] vector_in,
	output logic             ack_out,
	// peripheral requests and bank selects
	input  wire logic [15:0] set_req_in,
	input  wire logic        tx_bank_in,
	input  wire logic        rx_bank_in,
	input  wire logic [3:0]  wait_in,
	output logic [15:0]      req_out,
	output logic [15:0]      last_vec_out,
	output logic [7:0]       taken_out
);
	logic [3:0]  cnt;
	logic [15:0] hit;

	// bank-0 vector of each request bit; audio vectors move up by 0x30 in bank 1
	function automatic logic [15:0] src_vec(input int i, input logic txb, input logic rxb);
		logic [15:0] t [16];
		t = '{16'h001a, 16'h0014, 16'h0016, 16'h0010, 16'h0018, 16'h0012, 16'h002c, 16'h002a,
			16'h0022, 16'h0028, 16'h0020, 16'h0024, 16'h0034, 16'h0036, 16'h0032, 16'h0030};
		if (i < 6 && ((i % 2 == 1) ? txb : rxb)) return t[i] + 16'h0030;
		return t[i];
	endfunction

	// sources whose vector is the one on offer
	always_comb begin
		for (int i = 0; i < 16; i++) hit[i] = (src_vec(i, tx_bank_in, rx_bank_in) == vector_in);
	end

	// ack after wait_in cycles of offer; a serviced source drops its own request
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_out <= 1'b0;
			cnt <= 4'h0;
			req_out <= 16'h0000;
			last_vec_out <= 16'h0000;
			taken_out <= 8'h00;
		end else begin
			ack_out <= valid_in && !ack_out && cnt >= wait_in;
			cnt <= (valid_in && !ack_out) ? cnt + 4'h1 : 4'h0;
			req_out <= (req_out | set_req_in) & ~((ack_out && valid_in) ? hit : 16'h0000);
			if (ack_out && valid_in) begin
				last_vec_out <= vector_in;
				taken_out <= taken_out + 8'h01;
			end
		end
	end
endmodule // core_sequencer_model

/* File: verification/test_priority_interrupt_controller.sv */
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
module test_priority_interrupt_controller;
	logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic        ext_a = 1, ext_b = 1, tx_b = 0, rx_b = 0, ack, awr, wr, bv, arr, rv, vv;
	logic [4:0]  nm = 0;
	logic [17:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0]  bresp, rresp, vlvl, alvl;
	logic [15:0] vec, req, lvec, set = 0;
	logic [3:0]  wait_c = 0;
	logic [7:0]  taken, seen = 0;
	int          n_fail = 0, check_count = 0;

	priority_interrupt_controller uut (
		.sys_clk_in(clk), .reset_n_in(rst_n), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
		.ext_request_a_n_in(ext_a), .ext_request_b_n_in(ext_b), .illegal_instr_in(nm[0]),
		.nmi_in(nm[1]), .stack_error_in(nm[2]), .trace_in(nm[3]), .software_trap_in(nm[4]),
		.audio_req_in(req[5:0]), .host_req_in(req[11:6]), .memory_req_in(req[15:12]),
		.vector_valid_out(vv), .vector_out(vec), .vector_level_out(vlvl), .vector_ack_in(ack));

	core_sequencer_model core (
		.clk_in(clk), .reset_n_in(rst_n), .valid_in(vv), .vector_in(vec), .ack_out(ack),
		.set_req_in(set), .tx_bank_in(tx_b), .rx_bank_in(rx_b), .wait_in(wait_c),
		.req_out(req), .last_vec_out(lvec), .taken_out(taken));

	// 100 MHz clock
	always #5 clk = ~clk;

	// level of each acknowledged vector, taken at the acknowledge edge
	always @(posedge clk) begin
		if (ack && vv) alvl <= vlvl;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one write: address and data offered together, bready held until bvalid
	task automatic wr_reg(input logic [17:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
		do begin
			@(posedge clk);
			if (awr && awv) awv <= 0;
			if (wr && wv) wv <= 0;
		end while (!bv);
		bready <= 0;
		check({30'h0, bresp}, {30'h0, pic_pkg::RESP_OKAY});
	endtask

	// one read, data and response compared at the handshake edge
	task automatic rd_reg(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= a; arv <= 1; rready <= 1;
		do begin
			@(posedge clk);
			if (arr && arv) arv <= 0;
		end while (!rv);
		rready <= 0;
		check(rdata, e);
		check({30'h0, rresp}, {30'h0, er});
	endtask

	// waits for the next acknowledged vector and compares it
	task automatic nv(input logic [15:0] e, input logic [1:0] el = 2'h3);
		while (taken != seen + 8'h01) @(negedge clk);
		seen++;
		check({16'h0, lvec}, {16'h0, e});
		check({30'h0, alvl}, {30'h0, el});
	endtask

	task automatic pulse_set(input logic [15:0] s);
		@(posedge clk);
		set <= s;
		@(posedge clk);
		set <= 16'h0000;
	endtask

	task print_verdict;
		$display("checks=%0d mismatches=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		#200us;
		n_fail++;
		print_verdict();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		nv(16'h0000);
		rd_reg(pic_pkg::LEVEL_CFG_ADDR, 32'h0, pic_pkg::RESP_OKAY);
		rd_reg(pic_pkg::CTRL_ADDR, 32'h0000_0300, pic_pkg::RESP_OKAY);
		wr_reg(pic_pkg::LEVEL_CFG_ADDR, 32'hffff_ffff);
		rd_reg(pic_pkg::LEVEL_CFG_ADDR, 32'h0000_fc3f, pic_pkg::RESP_OKAY);
		rd_reg(18'h0_0000, 32'h0, pic_pkg::RESP_SLVERR);
		// audio at level 1, host at level 2, both held off by the reset mask
		wr_reg(pic_pkg::LEVEL_CFG_ADDR, 32'h0000_3800);
		pulse_set(16'h0801);
		repeat (20) @(negedge clk);
		check({24'h0, taken}, {24'h0, seen});
		wr_reg(pic_pkg::CTRL_ADDR, 32'h0000_0100);
		nv(16'h0024, 2'h2);
		nv(16'h001a, 2'h1);
		// all peripheral sources at one level, both banks, prompt then slow core
		wr_reg(pic_pkg::LEVEL_CFG_ADDR, 32'h0000_5400);
		for (int b = 0; b < 2; b++) begin
			wr_reg(pic_pkg::CTRL_ADDR, b ? 32'h0000_0003 : 32'h0000_0000);
			tx_b <= b[0];
			rx_b <= b[0];
			wait_c <= b ? 4'd3 : 4'd0;
			pulse_set(16'hffff);
			for (int i = 0; i < 16; i++) nv(core.src_vec(i, b[0], b[0]), 2'h0);
		end
		// both external requests in edge mode at the same level
		wr_reg(pic_pkg::LEVEL_CFG_ADDR, 32'h0000_002d);
		@(posedge clk);
		ext_a <= 0;
		ext_b <= 0;
		nv(16'h0008, 2'h0);
		nv(16'h000a, 2'h0);
		@(posedge clk);
		ext_a <= 1;
		ext_b <= 1;
		// all nonmaskable events in one cycle
		nm <= 5'h1f;
		@(posedge clk);
		nm <= 5'h00;
		nv(16'h003e);
		nv(16'h001e);
		nv(16'h0002);
		nv(16'h0004);
		nv(16'h0006);
		// second reset in mid-run clears the configuration and restarts at the reset vector
		@(posedge clk);
		rst_n <= 0;
		@(posedge clk);
		rst_n <= 1;
		seen = 0;
		nv(16'h0000);
		rd_reg(pic_pkg::LEVEL_CFG_ADDR, 32'h0, pic_pkg::RESP_OKAY);
		rd_reg(pic_pkg::CTRL_ADDR, 32'h0000_0300, pic_pkg::RESP_OKAY);
		print_verdict();
	end
endmodule // test_priority_interrupt_controller
